// *** core/spfm_pkg.sv ***
package spfm_pkg;
    localparam int PA_W  = 4;
    localparam int PB_W  = 8;
    localparam int PIN_W = 13;
    // pin index layout in the flat pin vector
    localparam int PA_LSB = 0;
    localparam int PB_LSB = 4;
    localparam int PC_LSB = 12;
    // port b positions of shared functions
    localparam int PB_SCMP_LSB = 0;
    localparam int PB_TCMP_LSB = 3;
    localparam int PB_TDIR     = 6;
    localparam int PB_TCLK     = 7;
    localparam int CMP_W       = 3;
    // reset values: bit i/o, input, low
    localparam logic [PIN_W-1:0] SEL_RST = 13'h0000;
    localparam logic [PIN_W-1:0] DIR_RST = 13'h0000;
    localparam logic [PIN_W-1:0] DAT_RST = 13'h0000;

    typedef struct packed {
        logic [PIN_W-1:0] func_sel;
        logic [PIN_W-1:0] dir_out;
        logic [PIN_W-1:0] data_out;
    } spfm_cfg_t;

    typedef struct packed {
        logic [CMP_W-1:0] simple_compare_out;
        logic [CMP_W-1:0] timer_compare_out;
        logic             pdp_mask;
    } spfm_periph_t;
endpackage : spfm_pkg

// *** core/spfm_mux.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1 - reset leaves every shared pin digital input
// RULE2 - port a bits feed two converters
// RULE3 - port b 0..2 carry simple compare outputs
// RULE4 - simple compare pins tristate on protect low
// RULE5 - timer compares on b3..5, tristate too
// RULE6 - direction pin low up, high down
// RULE7 - port b7 routes external timer clock
// RULE8 - port c0 routes conversion start trigger
// RULE9 - select, direction, data bit per pin
module spfm_mux (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire spfm_pkg::spfm_cfg_t    cfg,
    input  wire spfm_pkg::spfm_periph_t periph,
    input  wire logic                   power_drive_protect_in,
    input  wire logic [12:0]            pin_in,
    output logic      [12:0]            pin_out,
    output logic      [12:0]            pin_oe,
    output logic      [12:0]            bit_io_in,
    output logic      [1:0]             conv1_analog_en,
    output logic      [1:0]             conv2_analog_en,
    output logic                        timer_count_down,
    output logic                        timer_ext_clock_in,
    output logic                        timer_ext_clock_valid,
    output logic                        conv_start_trigger_in,
    output logic                        conv_start_valid
);
    logic [12:0] sync1_q;
    logic [12:0] sync2_q;
    logic [12:0] sync1_d;
    logic [12:0] sync2_d;
    logic [12:0] out_q;
    logic [12:0] out_d;
    logic [12:0] oe_q;
    logic [12:0] oe_d;
    logic [12:0] in_q;
    logic [12:0] in_d;
    logic [1:0]  a1_q;
    logic [1:0]  a1_d;
    logic [1:0]  a2_q;
    logic [1:0]  a2_d;
    logic        pdp1_q;
    logic        pdp2_q;
    logic        pdp1_d;
    logic        pdp2_d;
    logic        dn_q;
    logic        dn_d;
    logic        clk_q;
    logic        clk_d;
    logic        clkv_q;
    logic        clkv_d;
    logic        soc_q;
    logic        soc_d;
    logic        socv_q;
    logic        socv_d;
    logic        trip;

    // two-flop synchronisers for pins and protect input
    always_comb begin
        sync1_d = pin_in;
        sync2_d = sync1_q;
        pdp1_d  = power_drive_protect_in;
        pdp2_d  = pdp1_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_q <= 13'h0000;
            sync2_q <= 13'h0000;
            pdp1_q  <= 1'h1;
            pdp2_q  <= 1'h1;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            pdp1_q  <= pdp1_d;
            pdp2_q  <= pdp2_d;
        end
    end

    // pin drive: bit i/o when not selected, compare output when a compare is selected, released for other functions
    always_comb begin
        trip  = !periph.pdp_mask && !pdp2_q;
        in_d  = sync2_q;
        out_d = cfg.data_out;
        oe_d  = cfg.dir_out & ~cfg.func_sel; // RULE9
        for (int i = 0; i < spfm_pkg::CMP_W; i++) begin
            if (cfg.func_sel[spfm_pkg::PB_LSB + spfm_pkg::PB_SCMP_LSB + i]) begin
                out_d[spfm_pkg::PB_LSB + spfm_pkg::PB_SCMP_LSB + i] = periph.simple_compare_out[i]; // RULE3
                oe_d[spfm_pkg::PB_LSB + spfm_pkg::PB_SCMP_LSB + i]  = !trip; // RULE4
            end
            if (cfg.func_sel[spfm_pkg::PB_LSB + spfm_pkg::PB_TCMP_LSB + i]) begin
                out_d[spfm_pkg::PB_LSB + spfm_pkg::PB_TCMP_LSB + i] = periph.timer_compare_out[i];
                oe_d[spfm_pkg::PB_LSB + spfm_pkg::PB_TCMP_LSB + i]  = !trip; // RULE5
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            out_q <= spfm_pkg::DAT_RST;
            oe_q  <= spfm_pkg::DIR_RST; // RULE1
            in_q  <= 13'h0000;
        end else begin
            out_q <= out_d;
            oe_q  <= oe_d;
            in_q  <= in_d;
        end
    end

    // peripheral inputs, forced low when not selected
    always_comb begin
        a1_d   = cfg.func_sel[spfm_pkg::PA_LSB +: 2]; // RULE2
        a2_d   = cfg.func_sel[spfm_pkg::PA_LSB + 2 +: 2]; // RULE2
        dn_d   = cfg.func_sel[spfm_pkg::PB_LSB + spfm_pkg::PB_TDIR]
                 && sync2_q[spfm_pkg::PB_LSB + spfm_pkg::PB_TDIR]; // RULE6
        clkv_d = cfg.func_sel[spfm_pkg::PB_LSB + spfm_pkg::PB_TCLK];
        clk_d  = clkv_d && sync2_q[spfm_pkg::PB_LSB + spfm_pkg::PB_TCLK]; // RULE7
        socv_d = cfg.func_sel[spfm_pkg::PC_LSB];
        soc_d  = socv_d && sync2_q[spfm_pkg::PC_LSB]; // RULE8
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            a1_q   <= 2'h0;
            a2_q   <= 2'h0;
            dn_q   <= 1'h0;
            clk_q  <= 1'h0;
            clkv_q <= 1'h0;
            soc_q  <= 1'h0;
            socv_q <= 1'h0;
        end else begin
            a1_q   <= a1_d;
            a2_q   <= a2_d;
            dn_q   <= dn_d;
            clk_q  <= clk_d;
            clkv_q <= clkv_d;
            soc_q  <= soc_d;
            socv_q <= socv_d;
        end
    end

    assign pin_out               = out_q;
    assign pin_oe                = oe_q;
    assign bit_io_in             = in_q;
    assign conv1_analog_en       = a1_q;
    assign conv2_analog_en       = a2_q;
    assign timer_count_down      = dn_q;
    assign timer_ext_clock_in    = clk_q;
    assign timer_ext_clock_valid = clkv_q;
    assign conv_start_trigger_in = soc_q;
    assign conv_start_valid      = socv_q;

    AST_RESET_INPUT: assert property (@(posedge ref_clk) // RULE1
        !rst_n |=> pin_oe == 13'h0000)
        else $error("pins not inputs after reset");

    AST_RESET_QUIET: assert property (@(posedge ref_clk) // RULE1
        !rst_n |=> pin_out == 13'h0000 && bit_io_in == 13'h0000
            && conv1_analog_en == 2'h0 && conv2_analog_en == 2'h0 && !timer_count_down)
        else $error("outputs not quiet after reset");

    AST_ANALOG: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
        cfg.func_sel[3:0] == 4'hf |=> conv1_analog_en == 2'h3 && conv2_analog_en == 2'h3)
        else $error("analog routing wrong");

    AST_ANALOG_UNDRIVEN: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE2
        cfg.func_sel[3:0] == 4'hf |=> pin_oe[3:0] == 4'h0)
        else $error("analog pin driven");

    AST_SCMP_LEVEL: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE3
        cfg.func_sel[4] |=> pin_out[4] == $past(periph.simple_compare_out[0]))
        else $error("simple compare level wrong");

    sequence s_trip;
        !periph.pdp_mask && !power_drive_protect_in;
    endsequence

    AST_SCMP_TRIP: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE4
        s_trip [*3] ##0 (cfg.func_sel[6:4] == 3'h7) |=> pin_oe[6:4] == 3'h0)
        else $error("simple compare not tristated");

    AST_SCMP_MASKED: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE4
        periph.pdp_mask && cfg.func_sel[6:4] == 3'h7 |=> pin_oe[6:4] == 3'h7)
        else $error("masked protect released compare");

    AST_TCMP_LEVEL: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE5
        cfg.func_sel[7] |=> pin_out[7] == $past(periph.timer_compare_out[0]))
        else $error("timer compare level wrong");

    AST_TCMP_TRIP: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE5
        s_trip [*3] ##0 (cfg.func_sel[9:7] == 3'h7) |=> pin_oe[9:7] == 3'h0)
        else $error("timer compare not tristated");

    sequence s_dir_low;
        cfg.func_sel[10] && !pin_in[10] ##1 cfg.func_sel[10] ##1 cfg.func_sel[10];
    endsequence

    sequence s_dir_high;
        cfg.func_sel[10] && pin_in[10] ##1 cfg.func_sel[10] ##1 cfg.func_sel[10];
    endsequence

    AST_TDIR: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
        s_dir_low |=> !timer_count_down)
        else $error("direction low must count up");

    AST_TDIR_DOWN: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
        s_dir_high |=> timer_count_down)
        else $error("direction high must count down");

    AST_TDIR_UNDRIVEN: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE6
        cfg.func_sel[10] |=> !pin_oe[10])
        else $error("direction pin driven");

    AST_TCLK: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE7
        !cfg.func_sel[11] |=> !timer_ext_clock_in && !timer_ext_clock_valid)
        else $error("timer clock leaks in bit io mode");

    AST_TCLK_ROUTE: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE7
        pin_in[11] ##2 cfg.func_sel[11] |=> timer_ext_clock_in && timer_ext_clock_valid)
        else $error("timer clock not routed");

    AST_SOC: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE8
        pin_in[12] ##2 cfg.func_sel[12] |=> conv_start_trigger_in)
        else $error("conversion trigger not routed");

    AST_SOC_GATE: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE8
        !cfg.func_sel[12] |=> !conv_start_trigger_in && !conv_start_valid)
        else $error("conversion trigger leaks in bit io mode");

    AST_BITIO: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE9
        !cfg.func_sel[0] |=> pin_oe[0] == $past(cfg.dir_out[0]) && pin_out[0] == $past(cfg.data_out[0]))
        else $error("bit io drive wrong");
endmodule : spfm_mux
`default_nettype wire

// *** verif/spfm_ext_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spfm_ext_model (
    input  wire logic [12:0] pin_out,
    input  wire logic [12:0] pin_oe,
    input  wire logic [12:0] src,
    output logic      [12:0] pin_in
);
    // sources drive released pins only; b6 level sets count direction
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & src);
endmodule : spfm_ext_model
`default_nettype wire

// *** verif/shared_pin_function_mux_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module shared_pin_function_mux_tb;
    typedef struct packed {
        logic [12:0] sel, dir, dat;
        logic [6:0]  per;
        logic        prot;
        logic [12:0] src, eoe, eout, ein;
        logic [4:0]  misc;
    } spfm_row_t;
    logic                   ref_clk = 0, rst_n = 0, prot = 1;
    spfm_pkg::spfm_cfg_t    cfg = '0;
    spfm_pkg::spfm_periph_t per = '0;
    logic [12:0]            src = '0, pin_in, pin_out, pin_oe, bio;
    logic [1:0]             c1, c2;
    logic                   tdn, tck, tcv, sot, sov;
    int                     n_mismatch = 0, num_checks = 0, cyc = 0;
    spfm_row_t rows[5] = '{
        '{13'h0000, 13'h1fff, 13'h1a5a, 7'h00, 1'b1, 13'h0000, 13'h1fff, 13'h1a5a, 13'h1a5a, 5'h00},
        '{13'h1fff, 13'h0000, 13'h0000, 7'h54, 1'b1, 13'h1c00, 13'h03f0, 13'h0150, 13'h1d50, 5'h1f},
        '{13'h03f0, 13'h1fff, 13'h0000, 7'h54, 1'b0, 13'h1c00, 13'h1c0f, 13'h0000, 13'h0000, 5'h00},
        '{13'h03f0, 13'h1fff, 13'h0000, 7'h55, 1'b0, 13'h1c00, 13'h1fff, 13'h0150, 13'h0150, 5'h00},
        '{13'h1fff, 13'h0000, 13'h0000, 7'h00, 1'b1, 13'h0000, 13'h03f0, 13'h0000, 13'h0000, 5'h05}};

    spfm_mux uut (.ref_clk(ref_clk), .rst_n(rst_n), .cfg(cfg), .periph(per),
        .power_drive_protect_in(prot), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .bit_io_in(bio), .conv1_analog_en(c1), .conv2_analog_en(c2), .timer_count_down(tdn),
        .timer_ext_clock_in(tck), .timer_ext_clock_valid(tcv), .conv_start_trigger_in(sot),
        .conv_start_valid(sov));
    spfm_ext_model ext (.pin_out(pin_out), .pin_oe(pin_oe), .src(src), .pin_in(pin_in));

    initial forever #5 ref_clk = ~ref_clk;

    task automatic check(input string nm, input logic [12:0] seen, input logic [12:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 400) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        repeat (3) @(negedge ref_clk);
        rst_n = 1;
        foreach (rows[i]) begin
            cfg = {rows[i].sel, rows[i].dir, rows[i].dat};
            per = rows[i].per;
            prot = rows[i].prot;
            src = rows[i].src;
            repeat (8) @(negedge ref_clk);
            check("pin_oe", pin_oe, rows[i].eoe);
            check("pin_out", pin_out & rows[i].eoe, rows[i].eout);
            check("bit_io_in", bio, rows[i].ein);
            check("conv_en", {9'h000, c2, c1}, {9'h000, rows[i].sel[3:0]});
            check("timer_soc", {8'h00, tdn, tck, tcv, sot, sov}, {8'h00, rows[i].misc});
        end
        // second reset while pins are driven
        rst_n = 0;
        @(negedge ref_clk);
        check("pin_oe", pin_oe, 13'h0000);
        check("pin_out", pin_out, 13'h0000);
        check("bit_io_in", bio, 13'h0000);
        check("reset_misc", {4'h0, c2, c1, tdn, tck, tcv, sot, sov}, 13'h0000);
        cfg = '0;
        per = '0;
        prot = 1'b1;
        src = 13'h1fff;
        @(negedge ref_clk);
        rst_n = 1;
        repeat (2) @(negedge ref_clk);
        check("pin_oe", pin_oe, 13'h0000);
        repeat (4) @(negedge ref_clk);
        check("bit_io_in", bio, 13'h1fff);
        complete_run();
    end
endmodule : shared_pin_function_mux_tb
`default_nettype wire
